// *** rtl/ctir_top.sv ***
// cascaded 8-bit timers, envelope register and interrupt enable/flag logic
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// ************************************************************
module ctir_top
   import ctir_pkg::*;
(
   input wire logic clock, // 125 MHz core clock
   input wire logic rst, // synchronous, active high
   input wire logic [5:0] reg_addr, // register offset
   input wire logic [7:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [7:0] reg_rdata, // read data, cycle after strobe
   input wire logic fast_osc_tick, // one pulse per fast oscillator edge
   input wire logic slow_clk_tick, // one pulse per slow clock edge
   input wire logic timer0_count_msb, // bit 7 of the earlier timer count
   input wire logic timer0_event, // timer0 overflow pulse
   input wire logic timer0_stop_event, // timer0 stop pulse
   input wire logic timer0_stop_enable, // level: bit 2 means timer0 stop
   input wire logic fast_tick_event, // fast tick pulse
   input wire logic slow_tick_event, // slow tick pulse
   input wire logic external_pin_event, // external pin pulse
   input wire logic converter_event, // converter done pulse
   input wire logic key_strobe_event, // key strobe pulse
   output logic irq, // level request to the core
   output logic [2:0] irq_grant, // index of winning source
   output logic timer0_stop_req, // timer0 stop request level
   output logic [1:0] tone_channel_one_size, // tone table length code
   output logic [7:0] channel1_envelope, // envelope value
   output logic timer1_overflow, // one-cycle overflow pulse
   output logic timer2_overflow // one-cycle overflow pulse
);
   import ctir_pkg::*;

   // ************************************************************
   // helper functions
   // ************************************************************

   // true when every chain bit up to the tap is one, so the
   // next increment makes the tap fall: one pulse per 2^(k+1)
   function automatic logic ripple_hit(input logic [13:0] chain, input logic [3:0] k);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < CTIR_CHAIN_W; i++)
      begin
         if (i <= int'(k))
         begin
            ok = ok & chain[i];
         end
      end
      return ok;
   endfunction : ripple_hit

   // clock pick for either timer; t2 chooses the 1xxx tap group
   function automatic logic clock_pick(input logic [3:0] sel, input logic cascade,
      input logic [13:0] slow_c, input logic slow_t, input logic [13:0] fast_c,
      input logic fast_t, input logic t2);
      logic hit;
      logic [3:0] k;
      hit = 1'b0;
      k = 4'h0;
      casez (sel)
         4'b000?: hit = cascade; // cascade from previous timer
         4'b001?: hit = slow_t & ripple_hit(slow_c, CTIR_TAP_SLOW_16384);
         4'b0100: hit = slow_t & ripple_hit(slow_c, CTIR_TAP_SLOW_4096);
         4'b0101: hit = slow_t & ripple_hit(slow_c, CTIR_TAP_SLOW_1024);
         4'b0110: hit = slow_t & ripple_hit(slow_c, CTIR_TAP_SLOW_256);
         4'b0111: hit = slow_t & ripple_hit(slow_c, CTIR_TAP_SLOW_64);
         default:
         begin
            // fast taps: top tap minus low select bits
            if (t2)
            begin
               k = CTIR_TAP_T2_TOP - {1'b0, sel[2:0]};
               hit = fast_t & ripple_hit(fast_c, k);
            end
            else if (sel == CTIR_SEL_FAST_RAW)
            begin
               hit = fast_t;
            end
            else
            begin
               k = CTIR_TAP_T1_TOP - {1'b0, sel[2:0]};
               hit = fast_t & ripple_hit(fast_c, k);
            end
         end
      endcase
      return hit;
   endfunction : clock_pick

   // lowest set bit wins: timer2 first, key strobe last
   function automatic logic [2:0] first_set(input logic [7:0] v);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = 7; i >= 0; i--)
      begin
         if (v[i])
         begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction : first_set

   // ************************************************************
   // state
   // ************************************************************
   logic [13:0] slow_ripple_chain; // slow clock divider
   logic [13:0] fast_ripple_chain; // fast clock divider, low 9 bits used
   logic [7:0] timer1_count; // timer1 live count
   logic [7:0] timer1_preload_reg; // timer1 reload value
   logic [4:0] timer1_clock_mode; // [4] reload, [3:0] select
   logic timer1_run_reg; // timer1 running
   logic [1:0] tone_size_reg; // tone table length
   logic [7:0] envelope_reg; // channel1 envelope
   logic [7:0] timer2_count; // timer2 live count
   logic [7:0] timer2_preload_reg; // timer2 reload value
   logic [4:0] timer2_clock_mode; // [4] reload, [3:0] select
   logic timer2_run_reg; // timer2 running
   logic [7:0] interrupt_enables; // per-source enable
   logic [7:0] interrupt_flags; // sticky pending flags
   logic t0_msb_d; // last timer0 bit 7
   logic t1_msb_d; // last timer1 bit 7

   // ************************************************************
   // decode
   // ************************************************************
   logic wr_t1_count, wr_t1_mode, wr_t1_run, wr_env; // write hits
   logic wr_t2_count, wr_t2_mode, wr_t2_run, wr_en, wr_flag; // write hits
   logic t1_tick, t2_tick; // selected timer clocks
   logic t1_ovf, t2_ovf; // overflow this cycle
   logic [7:0] irq_src; // event pulses by bit
   logic [7:0] irq_clr; // flags cleared by software
   logic [7:0] flags_next; // next flag value
   logic [7:0] pending; // enabled flags
   logic [7:0] irq_mask; // sources that may raise irq

   assign wr_t1_count = reg_wr && (reg_addr == CTIR_OFS_T1_COUNT);
   assign wr_t1_mode = reg_wr && (reg_addr == CTIR_OFS_T1_MODE);
   assign wr_t1_run = reg_wr && (reg_addr == CTIR_OFS_T1_RUN);
   assign wr_env = reg_wr && (reg_addr == CTIR_OFS_CHANNEL1_ENVELOPE);
   assign wr_t2_count = reg_wr && (reg_addr == CTIR_OFS_T2_COUNT);
   assign wr_t2_mode = reg_wr && (reg_addr == CTIR_OFS_T2_MODE);
   assign wr_t2_run = reg_wr && (reg_addr == CTIR_OFS_T2_RUN);
   assign wr_en = reg_wr && (reg_addr == CTIR_OFS_IRQ_EN);
   assign wr_flag = reg_wr && (reg_addr == CTIR_OFS_IRQ_FLAG);

   // ************************************************************
   // ripple chains
   // ************************************************************

   // both dividers free-run so taps stay phase-stable across selects
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         slow_ripple_chain <= 14'h0000;
      end
      else if (slow_clk_tick)
      begin
         slow_ripple_chain <= slow_ripple_chain + 14'h0001;
      end
   end

   // fast chain, only the low nine taps are ever picked
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         fast_ripple_chain <= 14'h0000;
      end
      else if (fast_osc_tick)
      begin
         fast_ripple_chain <= fast_ripple_chain + 14'h0001;
      end
   end

   // ************************************************************
   // clock selection
   // ************************************************************

   // cascade edges: bit 7 falling means a count wrap
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         t0_msb_d <= 1'b0;
         t1_msb_d <= 1'b0;
      end
      else
      begin
         t0_msb_d <= timer0_count_msb;
         t1_msb_d <= timer1_count[7];
      end
   end

   // timer1 tap, raw and /2 at the top of the fast group
   assign t1_tick = clock_pick(timer1_clock_mode[3:0], t0_msb_d & ~timer0_count_msb,
      slow_ripple_chain, slow_clk_tick, fast_ripple_chain, fast_osc_tick, 1'b0);

   // timer2 tap, cascade from timer1 bit 7 or a chain tap
   assign t2_tick = clock_pick(timer2_clock_mode[3:0], t1_msb_d & ~timer1_count[7],
      slow_ripple_chain, slow_clk_tick, fast_ripple_chain, fast_osc_tick, 1'b1);

   assign t1_ovf = t1_tick && timer1_run_reg && (timer1_count == CTIR_COUNT_TOP);
   assign t2_ovf = t2_tick && timer2_run_reg && (timer2_count == CTIR_COUNT_TOP);

   // ************************************************************
   // timer1
   // ************************************************************

   // mode register; the cascade path only sees the live select
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         timer1_clock_mode <= CTIR_RST_T1_MODE;
      end
      else if (wr_t1_mode)
      begin
         timer1_clock_mode <= reg_wdata[4:0];
      end
   end

   // preload only; the live count is never written directly
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         timer1_preload_reg <= CTIR_RST_BYTE;
      end
      else if (wr_t1_count)
      begin
         timer1_preload_reg <= reg_wdata;
      end
   end

   // run bit and tone size; a software write beats a one-shot stop
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         timer1_run_reg <= 1'b0;
         tone_size_reg <= CTIR_RST_TONE;
      end
      else if (wr_t1_run)
      begin
         timer1_run_reg <= reg_wdata[CTIR_BIT_RUN];
         tone_size_reg <= reg_wdata[CTIR_BIT_TONE_HI:CTIR_BIT_TONE_LO];
      end
      else if (t1_ovf && !timer1_clock_mode[CTIR_BIT_RELOAD])
      begin
         timer1_run_reg <= 1'b0;
      end
   end

   // count up; a start from stopped loads the preload first
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         timer1_count <= CTIR_RST_BYTE;
      end
      else if (wr_t1_run && reg_wdata[CTIR_BIT_RUN] && !timer1_run_reg)
      begin
         timer1_count <= timer1_preload_reg;
      end
      else if (t1_ovf)
      begin
         // one-shot also reloads so a restart is predictable
         timer1_count <= timer1_preload_reg;
      end
      else if (t1_tick && timer1_run_reg)
      begin
         timer1_count <= timer1_count + 8'h01;
      end
   end

   // ************************************************************
   // envelope
   // ************************************************************

   // plain storage handed to the tone generator
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         envelope_reg <= CTIR_RST_BYTE;
      end
      else if (wr_env)
      begin
         envelope_reg <= reg_wdata;
      end
   end

   // ************************************************************
   // timer2
   // ************************************************************

   // mode register, reset to the fast/8 tap
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         timer2_clock_mode <= CTIR_RST_T2_MODE;
      end
      else if (wr_t2_mode)
      begin
         timer2_clock_mode <= reg_wdata[4:0];
      end
   end

   // writes to the data address go to preload, not the count
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         timer2_preload_reg <= CTIR_RST_BYTE;
      end
      else if (wr_t2_count)
      begin
         timer2_preload_reg <= reg_wdata;
      end
   end

   // run bit; one-shot overflow halts it
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         timer2_run_reg <= 1'b0;
      end
      else if (wr_t2_run)
      begin
         timer2_run_reg <= reg_wdata[CTIR_BIT_RUN];
      end
      else if (t2_ovf && !timer2_clock_mode[CTIR_BIT_RELOAD])
      begin
         timer2_run_reg <= 1'b0;
      end
   end

   // count up; same start and overflow handling as timer1
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         timer2_count <= CTIR_RST_BYTE;
      end
      else if (wr_t2_run && reg_wdata[CTIR_BIT_RUN] && !timer2_run_reg)
      begin
         timer2_count <= timer2_preload_reg;
      end
      else if (t2_ovf)
      begin
         timer2_count <= timer2_preload_reg;
      end
      else if (t2_tick && timer2_run_reg)
      begin
         timer2_count <= timer2_count + 8'h01;
      end
   end

   // ************************************************************
   // interrupts
   // ************************************************************

   // event vector in enable-register order
   always_comb
   begin
      irq_src = 8'h00;
      irq_src[CTIR_IRQ_T2] = t2_ovf;
      irq_src[CTIR_IRQ_T1] = t1_ovf;
      // bit 2 carries the stop event when that feature is on
      irq_src[CTIR_IRQ_T0] = timer0_stop_enable ? timer0_stop_event : timer0_event;
      irq_src[CTIR_IRQ_FAST] = fast_tick_event;
      irq_src[CTIR_IRQ_SLOW] = slow_tick_event;
      irq_src[CTIR_IRQ_EXT] = external_pin_event;
      irq_src[CTIR_IRQ_CONV] = converter_event;
      irq_src[CTIR_IRQ_KEY] = key_strobe_event;
   end

   // a zero written at the flag address clears that bit
   assign irq_clr = wr_flag ? ~reg_wdata : 8'h00;
   // a new event in the clearing cycle survives
   assign flags_next = (interrupt_flags & ~irq_clr) | irq_src;
   assign pending = interrupt_flags & interrupt_enables;
   // stop use of bit 2 never requests a core interrupt
   assign irq_mask = timer0_stop_enable ? 8'hFB : 8'hFF;

   // enable register
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         interrupt_enables <= CTIR_RST_BYTE;
      end
      else if (wr_en)
      begin
         interrupt_enables <= reg_wdata;
      end
   end

   // sticky flags, held until software clears them
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         interrupt_flags <= CTIR_RST_BYTE;
      end
      else
      begin
         interrupt_flags <= flags_next;
      end
   end

   // level request and fixed-priority grant, both registered
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         irq <= 1'b0;
         irq_grant <= 3'h0;
         timer0_stop_req <= 1'b0;
      end
      else
      begin
         irq <= |(pending & irq_mask);
         irq_grant <= first_set(pending & irq_mask);
         timer0_stop_req <= timer0_stop_enable && pending[CTIR_IRQ_T0];
      end
   end

   // ************************************************************
   // outputs and read port
   // ************************************************************

   // registered copies for the tone path and overflow pulses
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         tone_channel_one_size <= CTIR_RST_TONE;
         channel1_envelope <= CTIR_RST_BYTE;
         timer1_overflow <= 1'b0;
         timer2_overflow <= 1'b0;
      end
      else
      begin
         tone_channel_one_size <= tone_size_reg;
         channel1_envelope <= envelope_reg;
         timer1_overflow <= t1_ovf;
         timer2_overflow <= t2_ovf;
      end
   end

   // read data valid only in the cycle after the strobe;
   // unmapped offsets and idle cycles return zero
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         reg_rdata <= 8'h00;
      end
      else if (reg_rd)
      begin
         unique case (reg_addr)
            CTIR_OFS_T1_COUNT: reg_rdata <= timer1_count;
            CTIR_OFS_T1_MODE: reg_rdata <= {3'h0, timer1_clock_mode};
            CTIR_OFS_T1_RUN: reg_rdata <= {5'h00, tone_size_reg, timer1_run_reg};
            CTIR_OFS_CHANNEL1_ENVELOPE: reg_rdata <= envelope_reg;
            CTIR_OFS_T2_COUNT: reg_rdata <= timer2_count;
            CTIR_OFS_T2_MODE: reg_rdata <= {3'h0, timer2_clock_mode};
            CTIR_OFS_T2_RUN: reg_rdata <= {7'h00, timer2_run_reg};
            CTIR_OFS_IRQ_EN: reg_rdata <= interrupt_enables;
            CTIR_OFS_IRQ_FLAG: reg_rdata <= interrupt_flags;
            default: reg_rdata <= 8'h00;
         endcase
      end
      else
      begin
         reg_rdata <= 8'h00;
      end
   end

endmodule : ctir_top
`default_nettype wire

// *** pkg/ctir_pkg.sv ***
// constants shared by the cascaded timer and interrupt register block
package ctir_pkg;
   // ************************************************************
   // register offsets
   // ************************************************************
   localparam logic [5:0] CTIR_OFS_T1_COUNT = 6'h04; // timer1 count / preload
   localparam logic [5:0] CTIR_OFS_T1_MODE = 6'h05; // timer1 clock mode
   localparam logic [5:0] CTIR_OFS_T1_RUN = 6'h06; // timer1 enable and tone size
   localparam logic [5:0] CTIR_OFS_CHANNEL1_ENVELOPE = 6'h07; // channel1 envelope
   localparam logic [5:0] CTIR_OFS_T2_COUNT = 6'h08; // timer2 count / preload
   localparam logic [5:0] CTIR_OFS_T2_MODE = 6'h09; // timer2 clock mode
   localparam logic [5:0] CTIR_OFS_T2_RUN = 6'h0A; // timer2 run control
   localparam logic [5:0] CTIR_OFS_IRQ_EN = 6'h0C; // interrupt enables
   localparam logic [5:0] CTIR_OFS_IRQ_FLAG = 6'h0D; // flags read, clear by zero
   // ************************************************************
   // field positions
   // ************************************************************
   localparam int CTIR_BIT_RELOAD = 4; // reload / one-shot select
   localparam int CTIR_BIT_RUN = 0; // timer run bit
   localparam int CTIR_BIT_TONE_LO = 1; // tone size low bit
   localparam int CTIR_BIT_TONE_HI = 2; // tone size high bit
   localparam int CTIR_IRQ_T2 = 0; // timer2 source
   localparam int CTIR_IRQ_T1 = 1; // timer1 source
   localparam int CTIR_IRQ_T0 = 2; // timer0 or timer0 stop source
   localparam int CTIR_IRQ_FAST = 3; // fast tick source
   localparam int CTIR_IRQ_SLOW = 4; // slow tick source
   localparam int CTIR_IRQ_EXT = 5; // external pin source
   localparam int CTIR_IRQ_CONV = 6; // converter source
   localparam int CTIR_IRQ_KEY = 7; // key strobe source
   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [4:0] CTIR_RST_T1_MODE = 5'h1E; // reload, fast/2 tap
   localparam logic [4:0] CTIR_RST_T2_MODE = 5'h1E; // reload, fast/8 tap
   localparam logic [7:0] CTIR_RST_BYTE = 8'h00; // cleared registers
   localparam logic [1:0] CTIR_RST_TONE = 2'h0; // 4 point table
   // ************************************************************
   // clock select codes and ripple taps
   // ************************************************************
   localparam logic [3:0] CTIR_SEL_FAST_RAW = 4'hF; // timer1 undivided fast clock
   localparam logic [3:0] CTIR_TAP_SLOW_16384 = 4'hD; // slow chain bit 13
   localparam logic [3:0] CTIR_TAP_SLOW_4096 = 4'hB; // slow chain bit 11
   localparam logic [3:0] CTIR_TAP_SLOW_1024 = 4'h9; // slow chain bit 9
   localparam logic [3:0] CTIR_TAP_SLOW_256 = 4'h7; // slow chain bit 7
   localparam logic [3:0] CTIR_TAP_SLOW_64 = 4'h5; // slow chain bit 5
   localparam logic [3:0] CTIR_TAP_T1_TOP = 4'h6; // code 1000 for timer1
   localparam logic [3:0] CTIR_TAP_T2_TOP = 4'h8; // code 1000 for timer2
   localparam int CTIR_CHAIN_W = 14; // ripple chain width
   localparam logic [7:0] CTIR_COUNT_TOP = 8'hFF; // overflow value
endpackage : ctir_pkg

// *** testbench/ctir_top_assertions.sv ***
// assertion checker for the cascaded timer and interrupt register block
`timescale 1ns/1ns
`default_nettype none
module ctir_top_assertions
   import ctir_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic timer0_stop_enable,
   input wire logic irq,
   input wire logic timer0_stop_req,
   input wire logic [1:0] tone_channel_one_size,
   input wire logic [7:0] channel1_envelope
);
   // ************************************************************
   // bus, copy and interrupt properties, one clock domain
   // ************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside answer cycle");
   a_hole_zero: assert property (reg_rd && reg_addr == 6'h0B
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   // outputs copy their register one edge after the write lands
   a_env_copy: assert property (reg_wr && reg_addr == CTIR_OFS_CHANNEL1_ENVELOPE
      |-> ##2 channel1_envelope == $past(reg_wdata, 2)) else $error("envelope copy wrong");
   a_env_read: assert property (reg_rd && reg_addr == CTIR_OFS_CHANNEL1_ENVELOPE
      |=> reg_rdata == channel1_envelope) else $error("envelope read wrong");
   a_tone_copy: assert property (reg_wr && reg_addr == CTIR_OFS_T1_RUN
      |-> ##2 tone_channel_one_size == $past(reg_wdata[2:1], 2)) else $error("tone size wrong");
   a_mask_all: assert property (reg_wr && reg_addr == CTIR_OFS_IRQ_EN && reg_wdata == 8'h00
      |-> ##2 !irq) else $error("irq with all sources masked");
   // level request: only software or the stop feature may drop it
   a_irq_hold: assert property ($fell(irq) |-> $past(reg_wr, 2)
      || $past(timer0_stop_enable) != $past(timer0_stop_enable, 3)) else $error("irq dropped");
   a_stop_gate: assert property (timer0_stop_req
      |-> timer0_stop_enable || $past(timer0_stop_enable)) else $error("stop request ungated");
endmodule : ctir_top_assertions
bind ctir_top ctir_top_assertions u_chk (.clock(clock), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .timer0_stop_enable(timer0_stop_enable), .irq(irq), .timer0_stop_req(timer0_stop_req),
   .tone_channel_one_size(tone_channel_one_size), .channel1_envelope(channel1_envelope));
`default_nettype wire

// *** testbench/ctir_top_test.sv ***
// self-checking bench for the cascaded timer and interrupt register block
`timescale 1ns/1ns
`default_nettype none
module ctir_top_test;
   import ctir_pkg::*;
   // ************************************************************
   // stimulus, results and bookkeeping
   // ************************************************************
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [5:0] reg_addr = 6'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic tick_f = 1'b0; // fast oscillator pulse
   logic stop_en = 1'b0;
   logic [6:0] ev = 7'h00; // timer0, timer0 stop, then flag sources 3 to 7
   logic rd_d = 1'b0; // a read answer is due this cycle
   logic [7:0] rnd = 8'h39; // lfsr state
   logic [7:0] reg_rdata, env;
   logic [2:0] grant;
   logic [1:0] tone;
   logic irq, stop_req, ov1, ov2;
   logic [7:0] exp_q[$];
   int n_fail = 0;
   int n_tests = 0;
   int n_ov1 = 0;
   int n_ov2 = 0;
   int cyc = 0;
   // reset values; the last offset is a hole in the map
   logic [5:0] ofs[8] = '{CTIR_OFS_T1_MODE, CTIR_OFS_T1_RUN, CTIR_OFS_CHANNEL1_ENVELOPE, CTIR_OFS_T2_MODE,
      CTIR_OFS_T2_RUN, CTIR_OFS_IRQ_EN, CTIR_OFS_IRQ_FLAG, 6'h0B};
   logic [7:0] rv[8] = '{8'h1E, 8'h00, 8'h00, 8'h1E, 8'h00, 8'h00, 8'h00, 8'h00};
   always #4 clock = ~clock;
   // slow chain shares the fast pulses; timer0 msb is tied
   ctir_top u_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fast_osc_tick(tick_f),
      .slow_clk_tick(tick_f), .timer0_count_msb(1'b0), .timer0_event(ev[0]),
      .timer0_stop_event(ev[1]), .timer0_stop_enable(stop_en), .fast_tick_event(ev[2]),
      .slow_tick_event(ev[3]), .external_pin_event(ev[4]), .converter_event(ev[5]),
      .key_strobe_event(ev[6]), .irq(irq), .irq_grant(grant), .timer0_stop_req(stop_req),
      .tone_channel_one_size(tone), .channel1_envelope(env), .timer1_overflow(ov1),
      .timer2_overflow(ov2));
   function logic [7:0] lfsr(input logic [7:0] s);
      lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      n_tests++;
      if (s !== e)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task final_report;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   // each bus task waits an edge first, so strobes never get two drives at once
   task wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [5:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clock);
      reg_rd <= 1'b0;
   endtask : rd
   // single pulses two cycles apart, then time for the late cascade detect
   task tick(input int n);
      repeat (n)
      begin
         @(posedge clock);
         tick_f <= 1'b1;
         @(posedge clock);
         tick_f <= 1'b0;
      end
      repeat (3) @(posedge clock);
   endtask : tick
   task pulse(input int i);
      @(posedge clock);
      ev[i] <= 1'b1;
      @(posedge clock);
      ev[i] <= 1'b0;
      repeat (2) @(posedge clock);
   endtask : pulse
   // read answers against the oldest note, overflow pulse counts, hang guard
   always @(posedge clock)
   begin
      cyc++;
      n_ov1 += ov1;
      n_ov2 += ov2;
      if (rd_d)
         chk("rdata", reg_rdata, exp_q.pop_front());
      rd_d <= reg_rd;
      if (cyc == 3000)
      begin
         n_fail++;
         final_report();
      end
   end
   initial
   begin
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++)
         rd(ofs[i], rv[i]);
      repeat (3)
      begin
         rnd = lfsr(rnd);
         wr(CTIR_OFS_CHANNEL1_ENVELOPE, rnd);
         rd(CTIR_OFS_CHANNEL1_ENVELOPE, rnd);
         wr(CTIR_OFS_T1_RUN, rnd & 8'hFE);
         rd(CTIR_OFS_T1_RUN, rnd & 8'h06);
         chk("tone", 8'(tone), 8'(rnd[2:1]));
         chk("envelope", env, rnd);
      end
      // timer1 on the raw fast clock, reload from FE
      wr(CTIR_OFS_T1_COUNT, 8'hFE);
      wr(CTIR_OFS_T1_MODE, 8'h1F);
      wr(CTIR_OFS_T1_RUN, 8'h01);
      rd(CTIR_OFS_T1_COUNT, 8'hFE);
      tick(1);
      rd(CTIR_OFS_T1_COUNT, 8'hFF);
      tick(1);
      rd(CTIR_OFS_T1_COUNT, 8'hFE);
      rd(CTIR_OFS_IRQ_FLAG, 8'h02);
      // timer2 cascaded on the fall of timer1 bit 7
      wr(CTIR_OFS_T2_COUNT, 8'hFF);
      wr(CTIR_OFS_T2_MODE, 8'h10);
      wr(CTIR_OFS_T2_RUN, 8'h01);
      rd(CTIR_OFS_T2_COUNT, 8'hFF);
      wr(CTIR_OFS_T1_COUNT, 8'h7F);
      tick(2);
      rd(CTIR_OFS_T2_COUNT, 8'hFF);
      rd(CTIR_OFS_IRQ_FLAG, 8'h03);
      wr(CTIR_OFS_IRQ_FLAG, 8'hFE);
      rd(CTIR_OFS_IRQ_FLAG, 8'h02);
      // timer2 halted, timer1 one-shot stops at its overflow
      wr(CTIR_OFS_T2_RUN, 8'h00);
      wr(CTIR_OFS_T1_MODE, 8'h0F);
      tick(131);
      rd(CTIR_OFS_T1_COUNT, 8'h7F);
      rd(CTIR_OFS_T1_RUN, 8'h00);
      rd(CTIR_OFS_T2_COUNT, 8'hFF);
      rd(CTIR_OFS_IRQ_FLAG, 8'h02);
      chk("t1 overflows", 8'(n_ov1), 8'h03);
      chk("t2 overflows", 8'(n_ov2), 8'h01);
      // tap division over 128 pulses
      wr(CTIR_OFS_T2_MODE, 8'h17);
      wr(CTIR_OFS_T2_COUNT, 8'h00);
      wr(CTIR_OFS_T2_RUN, 8'h01);
      wr(CTIR_OFS_T1_MODE, 8'h1E);
      wr(CTIR_OFS_T1_RUN, 8'h01);
      tick(64);
      wr(CTIR_OFS_T2_MODE, 8'h1F);
      tick(64);
      rd(CTIR_OFS_T2_COUNT, 8'h11);
      rd(CTIR_OFS_T1_COUNT, 8'hBF);
      // masking, priority and clearing
      chk("irq", 8'(irq), 8'h00);
      wr(CTIR_OFS_IRQ_EN, 8'h02);
      repeat (2) @(posedge clock);
      chk("irq", 8'(irq), 8'h01);
      chk("grant", 8'(grant), 8'h01);
      for (int i = 2; i < 7; i++)
         pulse(i);
      rd(CTIR_OFS_IRQ_FLAG, 8'hFA);
      wr(CTIR_OFS_IRQ_EN, 8'h80);
      repeat (2) @(posedge clock);
      chk("grant", 8'(grant), 8'h07);
      wr(CTIR_OFS_IRQ_EN, 8'hFF);
      repeat (2) @(posedge clock);
      chk("grant", 8'(grant), 8'h01);
      wr(CTIR_OFS_IRQ_FLAG, 8'h00);
      repeat (2) @(posedge clock);
      chk("irq", 8'(irq), 8'h00);
      // bit 2 moves over to the timer0 stop function
      stop_en <= 1'b1;
      wr(CTIR_OFS_IRQ_EN, 8'h04);
      pulse(0);
      rd(CTIR_OFS_IRQ_FLAG, 8'h00);
      pulse(1);
      chk("stop req", 8'(stop_req), 8'h01);
      chk("irq", 8'(irq), 8'h00);
      rd(CTIR_OFS_IRQ_FLAG, 8'h04);
      wr(CTIR_OFS_IRQ_FLAG, 8'h00);
      stop_en <= 1'b0;
      pulse(0);
      chk("irq", 8'(irq), 8'h01);
      wr(CTIR_OFS_IRQ_EN, 8'h00);
      repeat (2) @(posedge clock);
      chk("irq", 8'(irq), 8'h00);
      repeat (3) @(posedge clock);
      final_report();
   end
endmodule : ctir_top_test
`default_nettype wire
